/* include/ppoc_pkg.sv */
// constants and types for the second-loop detector and oscillator output config block
package ppoc_pkg;

    // ------------------------------------------------------------
    // bus and register layout
    // ------------------------------------------------------------
    localparam int PPOC_ADDR_W = 8;
    localparam int PPOC_DATA_W = 32;
    localparam int PPOC_BE_W = 4;
    localparam int PPOC_REG_W = 8;
    localparam int PPOC_NUM_REGS = 5;
    localparam int PPOC_NUM_DRIVERS = 2;
    localparam int PPOC_IDX_W = 6;
    localparam logic [5:0] PPOC_IDX_PUMP = 6'h37;
    localparam logic [5:0] PPOC_IDX_DET = 6'h38;
    localparam logic [5:0] PPOC_IDX_PATH = 6'h39;
    localparam logic [5:0] PPOC_IDX_DRV0 = 6'h3a;
    localparam logic [5:0] PPOC_IDX_DRV1 = 6'h3b;
    localparam logic [5:0] PPOC_IDX_STATUS = 6'h3e;
    localparam logic [2:0] PPOC_SLOT_PUMP = 3'h0;
    localparam logic [2:0] PPOC_SLOT_DET = 3'h1;
    localparam logic [2:0] PPOC_SLOT_PATH = 3'h2;
    localparam logic [2:0] PPOC_SLOT_DRV0 = 3'h3;
    localparam logic [2:0] PPOC_SLOT_STATUS = 3'h5;
    localparam logic [7:0] PPOC_REG_RESET = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PPOC_PUMP_CODE_LSB = 0;
    localparam int PPOC_PUMP_CODE_W = 4;
    localparam int PPOC_DET_UP_EN_BIT = 4;
    localparam int PPOC_DET_DN_EN_BIT = 3;
    localparam int PPOC_DET_FORCE_UP_BIT = 2;
    localparam int PPOC_DET_FORCE_DN_BIT = 1;
    localparam int PPOC_DET_POL_BIT = 0;
    localparam int PPOC_PATH_DIV_LSB = 1;
    localparam int PPOC_PATH_EN_BIT = 0;
    localparam int PPOC_DRV_MODE_LSB = 4;
    localparam int PPOC_DRV_TERM_LSB = 1;
    localparam int PPOC_DRV_EN_BIT = 0;
    localparam int PPOC_STAT_UP_BIT = 0;
    localparam int PPOC_STAT_DN_BIT = 1;
    localparam int PPOC_STAT_PATH_BIT = 2;
    localparam int PPOC_STAT_CONFLICT_BIT = 3;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int PPOC_SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PPOC_DIV_1 = 2'b00,
        PPOC_DIV_2 = 2'b01,
        PPOC_DIV_4 = 2'b10,
        PPOC_DIV_8 = 2'b11
    } ppoc_div_t;

    typedef enum logic [1:0] {
        PPOC_MODE_CML = 2'b00,
        PPOC_MODE_ECL = 2'b01,
        PPOC_MODE_LVDS = 2'b10,
        PPOC_MODE_CMOS = 2'b11
    } ppoc_mode_t;

    typedef enum logic [1:0] {
        PPOC_TERM_OFF = 2'b00,
        PPOC_TERM_100 = 2'b01,
        PPOC_TERM_RSVD = 2'b10,
        PPOC_TERM_50 = 2'b11
    } ppoc_term_t;

    typedef enum logic [0:0] {
        PPOC_BUS_IDLE = 1'b0,
        PPOC_BUS_ACK = 1'b1
    } ppoc_bus_state_t;

endpackage : ppoc_pkg

/* rtl/ppoc_osc_divider.sv */
// oscillator output path divider
`timescale 1ns/1ps
module ppoc_osc_divider (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic osc_level_in,
    input wire logic enable_in,
    input wire logic [1:0] divide_code_in,
    output logic div_out
);

    // ------------------------------------------------------------
    // edge count and toggle
    // ------------------------------------------------------------
    logic osc_prev_q;
    logic osc_prev_d;
    logic [1:0] edge_cnt_q;
    logic [1:0] edge_cnt_d;
    logic div_q;
    logic div_d;
    logic [1:0] last_edge;

    always_comb begin
        osc_prev_d = osc_level_in;
        edge_cnt_d = edge_cnt_q;
        div_d = div_q;
        case (ppoc_pkg::ppoc_div_t'(divide_code_in))
            ppoc_pkg::PPOC_DIV_2: last_edge = 2'h0;
            ppoc_pkg::PPOC_DIV_4: last_edge = 2'h1;
            ppoc_pkg::PPOC_DIV_8: last_edge = 2'h3;
            default: last_edge = 2'h0;
        endcase
        if (!enable_in) begin
            edge_cnt_d = 2'h0;
            div_d = 1'b0;
        end else if (divide_code_in == ppoc_pkg::PPOC_DIV_1) begin
            edge_cnt_d = 2'h0;
            div_d = osc_level_in;
        end else if (osc_level_in && !osc_prev_q) begin
            if (edge_cnt_q >= last_edge) begin
                edge_cnt_d = 2'h0;
                div_d = ~div_q;
            end else begin
                edge_cnt_d = edge_cnt_q + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            osc_prev_q <= 1'b0;
            edge_cnt_q <= 2'h0;
            div_q <= 1'b0;
        end else begin
            osc_prev_q <= osc_prev_d;
            edge_cnt_q <= edge_cnt_d;
            div_q <= div_d;
        end
    end

    assign div_out = div_q;

endmodule : ppoc_osc_divider

/* rtl/ppoc_osc_driver.sv */
// one oscillator output driver control
`timescale 1ns/1ps
module ppoc_osc_driver (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic path_in,
    input wire logic [7:0] ctrl_in,
    output logic enable_out,
    output logic data_out,
    output logic [1:0] mode_out,
    output logic [1:0] termination_out
);

    // ------------------------------------------------------------
    // driver state
    // ------------------------------------------------------------
    logic en_q;
    logic en_d;
    logic data_q;
    logic data_d;
    logic [1:0] mode_q;
    logic [1:0] mode_d;
    logic [1:0] term_q;
    logic [1:0] term_d;
    logic [1:0] term_code;

    always_comb begin
        en_d = ctrl_in[ppoc_pkg::PPOC_DRV_EN_BIT];
        mode_d = ctrl_in[ppoc_pkg::PPOC_DRV_MODE_LSB +: 2];
        term_code = ctrl_in[ppoc_pkg::PPOC_DRV_TERM_LSB +: 2];
        term_d = ppoc_pkg::PPOC_TERM_OFF;
        if (en_d && mode_d == ppoc_pkg::PPOC_MODE_CML
            && term_code != ppoc_pkg::PPOC_TERM_RSVD) begin
            term_d = term_code;
        end
        data_d = en_d & path_in;
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            en_q <= 1'b0;
            data_q <= 1'b0;
            mode_q <= ppoc_pkg::PPOC_MODE_CML;
            term_q <= ppoc_pkg::PPOC_TERM_OFF;
        end else begin
            en_q <= en_d;
            data_q <= data_d;
            mode_q <= mode_d;
            term_q <= term_d;
        end
    end

    assign enable_out = en_q;
    assign data_out = data_q;
    assign mode_out = mode_q;
    assign termination_out = term_q;

endmodule : ppoc_osc_driver

/* rtl/ppoc_config.sv */
// register slice for second-loop detector and oscillator output paths
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// ------------------------------------------------------------
// ------------------------------------------------------------
module ppoc_config #(
    parameter int SYNC_STAGES = ppoc_pkg::PPOC_SYNC_STAGES
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic detector_up_raw_in,
    input wire logic detector_down_raw_in,
    input wire logic osc_in,
    output logic [3:0] loop2_pump_current_code_out,
    output logic pump_up_out,
    output logic pump_down_out,
    output logic osc_output_path_enable_out,
    output logic osc_path_out,
    output logic [1:0] osc_driver_enable_out,
    output logic [1:0] osc_driver_data_out,
    output logic [3:0] osc_driver_mode_code_out,
    output logic [3:0] osc_driver_termination_code_out
);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (SYNC_STAGES < 2) begin : g_bad_sync
        $error("SYNC_STAGES must be at least 2");
    end

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic [3:0] ppoc_decode(input logic [7:0] addr);
        logic [5:0] idx;
        logic [3:0] res;
        idx = addr[7:2];
        res = 4'h0;
        if (addr[1:0] == 2'b00) begin
            case (idx)
                ppoc_pkg::PPOC_IDX_PUMP: res = {1'b1, ppoc_pkg::PPOC_SLOT_PUMP};
                ppoc_pkg::PPOC_IDX_DET: res = {1'b1, ppoc_pkg::PPOC_SLOT_DET};
                ppoc_pkg::PPOC_IDX_PATH: res = {1'b1, ppoc_pkg::PPOC_SLOT_PATH};
                ppoc_pkg::PPOC_IDX_DRV0: res = {1'b1, ppoc_pkg::PPOC_SLOT_DRV0};
                ppoc_pkg::PPOC_IDX_DRV1: res = {1'b1, 3'(ppoc_pkg::PPOC_SLOT_DRV0 + 3'h1)};
                ppoc_pkg::PPOC_IDX_STATUS: res = {1'b1, ppoc_pkg::PPOC_SLOT_STATUS};
                default: res = 4'h0;
            endcase
        end
        return res;
    endfunction : ppoc_decode

    // ------------------------------------------------------------
    // bus slave and register file
    // ------------------------------------------------------------
    ppoc_pkg::ppoc_bus_state_t bus_q;
    ppoc_pkg::ppoc_bus_state_t bus_d;
    logic [7:0] regs_q [ppoc_pkg::PPOC_NUM_REGS];
    logic [7:0] regs_d [ppoc_pkg::PPOC_NUM_REGS];
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [7:0] status_val;
    logic [3:0] rd_dec;
    logic [3:0] wr_dec;

    always_comb begin
        bus_d = bus_q;
        regs_d = regs_q;
        rdata_d = rdata_q;
        rd_dec = ppoc_decode(avs_address_in);
        wr_dec = rd_dec;
        case (bus_q)
            ppoc_pkg::PPOC_BUS_IDLE: begin
                if (avs_read_in) begin
                    bus_d = ppoc_pkg::PPOC_BUS_ACK;
                    rdata_d = 32'h0000_0000;
                    if (rd_dec[3] && rd_dec[2:0] == ppoc_pkg::PPOC_SLOT_STATUS) begin
                        rdata_d = {24'h00_0000, status_val};
                    end else if (rd_dec[3]) begin
                        rdata_d = {24'h00_0000, regs_q[rd_dec[2:0]]};
                    end
                end else if (avs_write_in) begin
                    bus_d = ppoc_pkg::PPOC_BUS_ACK;
                end
            end
            ppoc_pkg::PPOC_BUS_ACK: begin
                bus_d = ppoc_pkg::PPOC_BUS_IDLE;
                if (avs_write_in && wr_dec[3] && avs_byteenable_in[0]
                    && wr_dec[2:0] != ppoc_pkg::PPOC_SLOT_STATUS) begin
                    regs_d[wr_dec[2:0]] = avs_writedata_in[7:0];
                end
            end
            default: begin
                bus_d = ppoc_pkg::PPOC_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            bus_q <= ppoc_pkg::PPOC_BUS_IDLE;
            rdata_q <= 32'h0000_0000;
            for (int i = 0; i < ppoc_pkg::PPOC_NUM_REGS; i++) begin
                regs_q[i] <= ppoc_pkg::PPOC_REG_RESET;
            end
        end else begin
            bus_q <= bus_d;
            rdata_q <= rdata_d;
            regs_q <= regs_d;
        end
    end

    assign avs_waitrequest_out = (avs_read_in | avs_write_in)
                                 & (bus_q != ppoc_pkg::PPOC_BUS_ACK);
    assign avs_readdata_out = rdata_q;

    // ------------------------------------------------------------
    // field extraction
    // ------------------------------------------------------------
    logic [7:0] pump_reg;
    logic [7:0] det_reg;
    logic [7:0] path_reg;
    logic det_up_en;
    logic det_dn_en;
    logic det_force_up;
    logic det_force_dn;
    logic det_polarity;

    assign pump_reg = regs_q[ppoc_pkg::PPOC_SLOT_PUMP];
    assign det_reg = regs_q[ppoc_pkg::PPOC_SLOT_DET];
    assign path_reg = regs_q[ppoc_pkg::PPOC_SLOT_PATH];
    assign det_up_en = det_reg[ppoc_pkg::PPOC_DET_UP_EN_BIT];
    assign det_dn_en = det_reg[ppoc_pkg::PPOC_DET_DN_EN_BIT];
    assign det_force_up = det_reg[ppoc_pkg::PPOC_DET_FORCE_UP_BIT];
    assign det_force_dn = det_reg[ppoc_pkg::PPOC_DET_FORCE_DN_BIT];
    assign det_polarity = det_reg[ppoc_pkg::PPOC_DET_POL_BIT];

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [SYNC_STAGES-1:0] up_sync_q;
    logic [SYNC_STAGES-1:0] dn_sync_q;
    logic [SYNC_STAGES-1:0] osc_sync_q;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            up_sync_q <= '0;
            dn_sync_q <= '0;
            osc_sync_q <= '0;
        end else begin
            up_sync_q <= {up_sync_q[SYNC_STAGES-2:0], detector_up_raw_in};
            dn_sync_q <= {dn_sync_q[SYNC_STAGES-2:0], detector_down_raw_in};
            osc_sync_q <= {osc_sync_q[SYNC_STAGES-2:0], osc_in};
        end
    end

    // ------------------------------------------------------------
    // detector to charge pump
    // ------------------------------------------------------------
    logic pump_up_q;
    logic pump_up_d;
    logic pump_dn_q;
    logic pump_dn_d;
    logic [3:0] pump_code_q;
    logic [3:0] pump_code_d;
    logic det_up;
    logic det_dn;

    always_comb begin
        pump_code_d = pump_reg[ppoc_pkg::PPOC_PUMP_CODE_LSB +: ppoc_pkg::PPOC_PUMP_CODE_W];
        // negative polarity swaps detector directions
        det_up = det_polarity ? dn_sync_q[SYNC_STAGES-1] : up_sync_q[SYNC_STAGES-1];
        det_dn = det_polarity ? up_sync_q[SYNC_STAGES-1] : dn_sync_q[SYNC_STAGES-1];
        pump_up_d = det_up_en & det_up & ~det_force_dn;
        pump_dn_d = det_dn_en & det_dn & ~det_force_up;
        if (det_force_up) begin
            pump_up_d = 1'b1;
        end
        if (det_force_dn) begin
            pump_dn_d = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pump_up_q <= 1'b0;
            pump_dn_q <= 1'b0;
            pump_code_q <= 4'h0;
        end else begin
            pump_up_q <= pump_up_d;
            pump_dn_q <= pump_dn_d;
            pump_code_q <= pump_code_d;
        end
    end

    assign loop2_pump_current_code_out = pump_code_q;
    assign pump_up_out = pump_up_q;
    assign pump_down_out = pump_dn_q;

    // ------------------------------------------------------------
    // oscillator output path
    // ------------------------------------------------------------
    logic path_en_q;
    logic path_en_d;
    logic path_div;

    always_comb begin
        path_en_d = path_reg[ppoc_pkg::PPOC_PATH_EN_BIT];
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            path_en_q <= 1'b0;
        end else begin
            path_en_q <= path_en_d;
        end
    end

    ppoc_osc_divider u_divider (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .osc_level_in(osc_sync_q[SYNC_STAGES-1]),
        .enable_in(path_reg[ppoc_pkg::PPOC_PATH_EN_BIT]),
        .divide_code_in(path_reg[ppoc_pkg::PPOC_PATH_DIV_LSB +: 2]),
        .div_out(path_div)
    );

    assign osc_output_path_enable_out = path_en_q;
    assign osc_path_out = path_div;

    // ------------------------------------------------------------
    // output drivers
    // ------------------------------------------------------------
    for (genvar g = 0; g < ppoc_pkg::PPOC_NUM_DRIVERS; g++) begin : g_drv
        ppoc_osc_driver u_driver (
            .clk_in(clk_in),
            .arst_n_in(arst_n_in),
            .path_in(path_div),
            .ctrl_in(regs_q[32'(ppoc_pkg::PPOC_SLOT_DRV0) + g]),
            .enable_out(osc_driver_enable_out[g]),
            .data_out(osc_driver_data_out[g]),
            .mode_out(osc_driver_mode_code_out[2*g +: 2]),
            .termination_out(osc_driver_termination_code_out[2*g +: 2])
        );
    end

    // ------------------------------------------------------------
    // status readback
    // ------------------------------------------------------------
    always_comb begin
        status_val = 8'h00;
        status_val[ppoc_pkg::PPOC_STAT_UP_BIT] = pump_up_q;
        status_val[ppoc_pkg::PPOC_STAT_DN_BIT] = pump_dn_q;
        status_val[ppoc_pkg::PPOC_STAT_PATH_BIT] = path_div;
        status_val[ppoc_pkg::PPOC_STAT_CONFLICT_BIT] = det_force_up & det_force_dn;
    end

endmodule : ppoc_config

/* verif/ppoc_config_sva.sv */
// port checker for the second-loop detector and oscillator output config block
`timescale 1ns/1ps
module ppoc_config_sva #(
    parameter int SYNC_STAGES = 2
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic avs_waitrequest_out,
    input wire logic [3:0] loop2_pump_current_code_out,
    input wire logic pump_up_out,
    input wire logic pump_down_out,
    input wire logic osc_output_path_enable_out,
    input wire logic osc_path_out,
    input wire logic [1:0] osc_driver_enable_out,
    input wire logic [1:0] osc_driver_data_out,
    input wire logic [3:0] osc_driver_mode_code_out,
    input wire logic [3:0] osc_driver_termination_code_out
);
    // ------------------------------------------------------------
    // accepted writes
    // ------------------------------------------------------------
    logic wr_ok;
    logic [7:0] wa;
    logic [7:0] wd;
    logic [3:0] tm;
    logic [3:0] md;
    assign wr_ok = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
    assign wa = avs_address_in;
    assign wd = avs_writedata_in[7:0];
    assign tm = osc_driver_termination_code_out;
    assign md = osc_driver_mode_code_out;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_ack_next;
        (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("no answer after request");
    property p_pump_code;
        wr_ok && wa == 8'hdc |=> ##1 loop2_pump_current_code_out == $past(wd[3:0], 2);
    endproperty
    a_pump_code: assert property (p_pump_code) else $error("pump code wrong");
    property p_det_off;
        wr_ok && wa == 8'he0 && wd[4:1] == 4'h0 |=> ##1 !pump_up_out && !pump_down_out;
    endproperty
    a_det_off: assert property (p_det_off) else $error("pump moves while gated");
    property p_force_dn;
        wr_ok && wa == 8'he0 && wd[2:1] == 2'h1 |=> ##1 pump_down_out && !pump_up_out;
    endproperty
    a_force_dn: assert property (p_force_dn) else $error("force down ignored");
    property p_force_up;
        wr_ok && wa == 8'he0 && wd[2:1] == 2'h2 |=> ##1 pump_up_out && !pump_down_out;
    endproperty
    a_force_up: assert property (p_force_up) else $error("force up ignored");
    property p_path_en;
        wr_ok && wa == 8'he4 |=> ##1 osc_output_path_enable_out == $past(wd[0], 2);
    endproperty
    a_path_en: assert property (p_path_en) else $error("path enable wrong");
    property p_path_off;
        !osc_output_path_enable_out [*3] |-> !osc_path_out;
    endproperty
    a_path_off: assert property (p_path_off) else $error("path runs while off");
    property p_drv_mode;
        wr_ok && wa == 8'he8 |=> ##1 md[1:0] == $past(wd[5:4], 2)
            && osc_driver_enable_out[0] == $past(wd[0], 2);
    endproperty
    a_drv_mode: assert property (p_drv_mode) else $error("driver mode wrong");
    property p_term;
        (tm[1:0] == 2'h0 || (osc_driver_enable_out[0] && md[1:0] == 2'h0 && tm[1:0] != 2'h2))
        && (tm[3:2] == 2'h0 || (osc_driver_enable_out[1] && md[3:2] == 2'h0 && tm[3:2] != 2'h2));
    endproperty
    a_term: assert property (p_term) else $error("termination outside cml");
    property p_drv_off;
        !osc_driver_enable_out[1] [*2] |-> !osc_driver_data_out[1];
    endproperty
    a_drv_off: assert property (p_drv_off) else $error("disabled driver toggles");
endmodule : ppoc_config_sva

bind ppoc_config ppoc_config_sva #(.SYNC_STAGES(SYNC_STAGES)) ppoc_config_sva_inst (
    .clk_in, .arst_n_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
    .avs_byteenable_in, .avs_waitrequest_out, .loop2_pump_current_code_out, .pump_up_out,
    .pump_down_out, .osc_output_path_enable_out, .osc_path_out, .osc_driver_enable_out,
    .osc_driver_data_out, .osc_driver_mode_code_out, .osc_driver_termination_code_out);

/* verif/testbench.sv */
// self-checking bench for the config block
`timescale 1ns/1ps
module testbench;
    logic clk_in;
    logic arst_n_in = 1'h0;
    logic avs_read_in = 1'h0;
    logic avs_write_in = 1'h0;
    logic [7:0] avs_address_in = 8'h00;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [3:0] avs_byteenable_in = 4'h0;
    logic detector_up_raw_in = 1'h0;
    logic detector_down_raw_in = 1'h0;
    logic osc_in = 1'h0;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic [3:0] loop2_pump_current_code_out;
    logic pump_up_out;
    logic pump_down_out;
    logic osc_output_path_enable_out;
    logic osc_path_out;
    logic [1:0] osc_driver_enable_out;
    logic [1:0] osc_driver_data_out;
    logic [3:0] osc_driver_mode_code_out;
    logic [3:0] osc_driver_termination_code_out;
    logic [31:0] q;
    logic cnt_on = 1'h0;
    logic po, d0, d1;
    int n_fail = 0;
    int compares = 0;
    int cyc = 0;
    int tp, t0, t1;
    int seed = 32'hf034f6fe;

    ppoc_config ppoc_config_inst (
        .clk_in, .arst_n_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
        .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .detector_up_raw_in,
        .detector_down_raw_in, .osc_in, .loop2_pump_current_code_out, .pump_up_out,
        .pump_down_out, .osc_output_path_enable_out, .osc_path_out, .osc_driver_enable_out,
        .osc_driver_data_out, .osc_driver_mode_code_out, .osc_driver_termination_code_out);

    // ------------------------------------------------------------
    // clock, timeout, toggle counters
    // ------------------------------------------------------------
    initial begin
        clk_in = 1'h0;
        forever #2 clk_in = !clk_in;
    end
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            final_report();
        end
    end
    always @(negedge clk_in) begin
        if (cnt_on) begin
            tp += int'(osc_path_out !== po);
            t0 += int'(osc_driver_data_out[0] !== d0);
            t1 += int'(osc_driver_data_out[1] !== d1);
        end
        po = osc_path_out;
        d0 = osc_driver_data_out[0];
        d1 = osc_driver_data_out[1];
    end

    // ------------------------------------------------------------
    // tasks and models
    // ------------------------------------------------------------
    task automatic check_reg(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %0t read %h exp %h", $time, g, e);
        end
    endtask : check_reg
    task automatic check_out(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %0t port %h exp %h", $time, g, e);
        end
    endtask : check_out
    task automatic bus_op(input logic wr, input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] be, output logic [31:0] r);
        @(posedge clk_in);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_byteenable_in <= be;
        avs_read_in <= !wr;
        avs_write_in <= wr;
        do begin
            @(posedge clk_in);
        end while (avs_waitrequest_out !== 1'h0);
        r = avs_readdata_out;
        avs_read_in <= 1'h0;
        avs_write_in <= 1'h0;
    endtask : bus_op
    function automatic logic [1:0] exp_pump(input logic [7:0] c, input logic u, input logic d);
        logic su, sd;
        su = c[0] ? d : u;
        sd = c[0] ? u : d;
        return {c[2] | (!c[1] & c[4] & su), c[1] | (!c[2] & c[3] & sd)};
    endfunction : exp_pump
    function automatic logic [1:0] exp_term(input logic [7:0] c);
        return (c[0] && c[5:4] == 2'h0 && c[2:1] != 2'h2) ? c[2:1] : 2'h0;
    endfunction : exp_term
    task automatic final_report();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : final_report

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] v [5];
        logic [7:0] c;
        logic [1:0] p;
        int e;
        repeat (12) @(posedge clk_in);
        arst_n_in <= 1'h1;
        for (int i = 0; i < 5; i++) begin
            bus_op(1'h0, 8'hdc + 8'(4 * i), 32'h0, 4'hf, q);
            check_reg(q, 32'h0);
            v[i] = $random(seed);
            if (i == 1 && v[i][2]) v[i][1] = 1'h0;
            if (i > 2 && v[i][2:1] == 2'h2) v[i][2:1] = 2'h3;
            bus_op(1'h1, 8'hdc + 8'(4 * i), v[i], 4'hf, q);
            v[i] = v[i] & 32'hff;
        end
        bus_op(1'h1, 8'hdd, 32'hff, 4'hf, q);
        bus_op(1'h1, 8'hdc, 32'hff, 4'he, q);
        bus_op(1'h1, 8'hf8, 32'hff, 4'hf, q);
        bus_op(1'h0, 8'h00, 32'h0, 4'hf, q);
        check_reg(q, 32'h0);
        for (int i = 0; i < 5; i++) begin
            bus_op(1'h0, 8'hdc + 8'(4 * i), 32'h0, 4'hf, q);
            check_reg(q, v[i]);
        end
        check_out(8'(loop2_pump_current_code_out), 8'(v[0][3:0]));
        for (int i = 0; i < 32; i++) begin
            c = {2'h0, 2'(i), 1'h0, 2'(i >> 2), 1'($random(seed))};
            if (c[2:1] == 2'h2) c[2:1] = 2'h3;
            e = i >> 4;
            bus_op(1'h1, e ? 8'hec : 8'he8, {24'h0, c}, 4'hf, q);
            repeat (2) @(negedge clk_in);
            check_out(8'(osc_driver_mode_code_out[2 * e +: 2]), 8'(c[5:4]));
            check_out(8'(osc_driver_enable_out[e]), 8'(c[0]));
            check_out(8'(osc_driver_termination_code_out[2 * e +: 2]), 8'(exp_term(c)));
        end
        for (int i = 0; i < 40; i++) begin
            c = (i < 3) ? 8'(2 * i) : 8'($random(seed)) & 8'h1f;
            if (c[2] && c[1]) c[1] = 1'h0;
            bus_op(1'h1, 8'he0, {24'h0, c}, 4'hf, q);
            detector_up_raw_in <= 1'($random(seed));
            detector_down_raw_in <= 1'($random(seed));
            repeat (5) @(negedge clk_in);
            p = exp_pump(c, detector_up_raw_in, detector_down_raw_in);
            check_out({6'h0, pump_up_out, pump_down_out}, {6'h0, p});
        end
        bus_op(1'h1, 8'he8, 32'h1, 4'hf, q);
        bus_op(1'h1, 8'hec, 32'h0, 4'hf, q);
        for (int k = 0; k < 4; k++) begin
            bus_op(1'h1, 8'he4, 32'h0, 4'hf, q);
            bus_op(1'h1, 8'he4, 32'(2 * k + 1), 4'hf, q);
            tp = 0;
            t0 = 0;
            t1 = 0;
            cnt_on <= 1'h1;
            repeat (32) begin
                repeat (8) @(posedge clk_in);
                osc_in <= !osc_in;
            end
            repeat (12) @(posedge clk_in);
            cnt_on <= 1'h0;
            check_out(8'(osc_output_path_enable_out), 8'h01);
            check_out(8'(tp), 8'(32 >> k));
            check_out(8'(t0), 8'(32 >> k));
            check_out(8'(t1), 8'h00);
        end
        final_report();
    end
endmodule : testbench
